// File: clk_ctrl_pkg.sv
// Purpose: Shared constants and types for the clock ratio and module halt block
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes: Register values sit in the low 16 bits, upper bits read zero
package clk_ctrl_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [23:0] CLOCK_RATIO_SELECT_ADDR = 24'hfffdc4;
	localparam logic [23:0] MODULE_HALT_CTRL_A_ADDR = 24'hfffdc8;
	localparam logic [23:0] MODULE_HALT_CTRL_B_ADDR = 24'hfffdcc;
	localparam logic [23:0] CLOCK_STATUS_ADDR = 24'hfffdd0;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int SYS_SEL_LSB = 8;
	localparam int PERIPH_SEL_LSB = 4;
	localparam int EXTBUS_SEL_LSB = 0;
	localparam int ALL_CLOCK_STOP_ENABLE_BIT = 15;
	localparam int HALT_DMA_CTRL_BIT = 13;
	localparam int HALT_TRANSFER_CTRL_BIT = 12;
	localparam int HALT_ADC_UNIT1_BIT = 4;
	localparam int HALT_ADC_UNIT0_BIT = 3;
	localparam int HALT_TIMER_UPPER_BIT = 1;
	localparam int HALT_TIMER_LOWER_BIT = 0;
	localparam int HALT_PULSE_PATTERN_BIT = 15;
	localparam int HALT_SERIAL_CH4_BIT = 12;
	localparam int HALT_SERIAL_CH3_BIT = 11;

	// Writable bits of each register
	localparam logic [15:0] CLOCK_RATIO_SELECT_MASK = 16'h0777;
	localparam logic [15:0] MODULE_HALT_CTRL_A_MASK = 16'hb01b;
	localparam logic [15:0] MODULE_HALT_CTRL_B_MASK = 16'h9800;
	// Halt bits of register a, without the all-stop enable
	localparam logic [15:0] HALT_A_MODULE_MASK = 16'h301b;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [15:0] CLOCK_RATIO_SELECT_RESET = 16'h0000;
	localparam logic [15:0] MODULE_HALT_CTRL_A_RESET = 16'h0000;
	localparam logic [15:0] MODULE_HALT_CTRL_B_RESET = 16'h0000;

	// ------------------------------------------------------------
	// Ratio codes and types
	// ------------------------------------------------------------
	localparam logic [2:0] RATIO_X8 = 3'h0;
	localparam logic [2:0] RATIO_X1 = 3'h3;

	typedef enum logic [1:0] {
		POWER_RUN = 2'b00,
		POWER_SLEEP = 2'b01,
		POWER_ALL_STOP = 2'b10
	} power_state_t;

	typedef struct packed {
		logic cpu;
		logic dma_ctrl;
		logic data_transfer_ctrl;
		logic adc_unit1;
		logic adc_unit0;
		logic timer_upper;
		logic timer_lower;
		logic pulse_pattern_gen;
		logic serial_ch4;
		logic serial_ch3;
		logic bus_ctrl;
		logic io_ports;
	} module_clk_en_t;

endpackage : clk_ctrl_pkg

// File: clk_ratio_div.sv
// Purpose: One derived clock, as a tick at a selected ratio of the core clock
// Assumes: Core clock stands for input clock times eight
// Notes: A new ratio takes effect only at the end of the running period
`timescale 1ns/1ps
module clk_ratio_div #(
	parameter int SEL_W = 3
) (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic [SEL_W-1:0] sel_in,
	output logic tick_out
);

	// Refused at elaboration, a wider select would overrun the counter
	if (SEL_W != 3) begin : g_bad_sel
		$error("clk_ratio_div supports a 3-bit select only");
	end

	// Codes above x1 are clamped, counter covers at most divide by eight
	function automatic logic [2:0] period_of(input logic [SEL_W-1:0] sel);
		logic [2:0] code;
		code = (sel > SEL_W'(clk_ctrl_pkg::RATIO_X1)) ? clk_ctrl_pkg::RATIO_X1 : sel[2:0];
		period_of = 3'((4'h1 << code) - 4'h1);
	endfunction : period_of

	logic [2:0] count;

	// ------------------------------------------------------------
	// Period counter
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			count <= 3'h0;
		end else if (count == 3'h0) begin
			count <= period_of(sel_in);
		end else begin
			count <= count - 3'h1;
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			tick_out <= 1'b0;
		end else begin
			tick_out <= (count == 3'h0);
		end
	end

endmodule : clk_ratio_div

// File: clock_select_module_stop.sv
// Purpose: Clock ratio selection, module halt and all-module clock stop
// Assumes: AHB-Lite slave on the core clock, zero wait states
// Notes: Derived clocks leave as one-cycle enable ticks per module
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps

module clock_select_module_stop #(
	parameter int REG_W = 16
) (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	input wire logic sleep_req_in,
	input wire logic wake_in,
	output clk_ctrl_pkg::module_clk_en_t clk_en_out,
	output logic sys_tick_out,
	output logic periph_tick_out,
	output logic extbus_tick_out,
	output logic all_stop_out
);

	// Refused at elaboration, field masks assume 16-bit registers
	if (REG_W != 16) begin : g_bad_width
		$error("clock_select_module_stop supports 16-bit registers only");
	end

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [REG_W-1:0] clock_ratio_select;
	logic [REG_W-1:0] module_halt_ctrl_a;
	logic [REG_W-1:0] module_halt_ctrl_b;
	logic wr_pending;
	logic [23:0] wr_addr;
	logic addr_phase;
	logic [31:0] next_rdata;
	logic sys_tick;
	logic periph_tick;
	logic extbus_tick;
	logic wake_meta;
	logic wake_s2;
	logic wake_s3;
	logic wake_level;
	logic all_halted;
	clk_ctrl_pkg::power_state_t power_state;
	clk_ctrl_pkg::power_state_t next_power_state;
	logic [2:0] sys_sel;
	logic [2:0] periph_sel;
	logic [2:0] extbus_sel;

	// Register lookup, used by reads and by the status view
	function automatic logic [31:0] read_word(
		input logic [23:0] addr,
		input logic [15:0] ratio,
		input logic [15:0] halt_a,
		input logic [15:0] halt_b,
		input logic [15:0] status
	);
		read_word = 32'h0000_0000;
		if (addr == clk_ctrl_pkg::CLOCK_RATIO_SELECT_ADDR) begin
			read_word = {16'h0000, ratio};
		end else if (addr == clk_ctrl_pkg::MODULE_HALT_CTRL_A_ADDR) begin
			read_word = {16'h0000, halt_a};
		end else if (addr == clk_ctrl_pkg::MODULE_HALT_CTRL_B_ADDR) begin
			read_word = {16'h0000, halt_b};
		end else if (addr == clk_ctrl_pkg::CLOCK_STATUS_ADDR) begin
			read_word = {16'h0000, status};
		end
	endfunction : read_word

	// Masked store of one register
	function automatic logic [15:0] masked_write(
		input logic [15:0] old_value,
		input logic [15:0] new_value,
		input logic [15:0] mask
	);
		masked_write = (old_value & ~mask) | (new_value & mask);
	endfunction : masked_write

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	assign addr_phase = hsel_in & hready_in & htrans_in[1];

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			wr_pending <= 1'b0;
			wr_addr <= 24'h000000;
		end else begin
			wr_pending <= addr_phase & hwrite_in;
			if (addr_phase) begin
				wr_addr <= haddr_in[23:0];
			end
		end
	end

	// Read data is taken in the address phase, so it stands in the data phase
	always_comb begin
		next_rdata = read_word(haddr_in[23:0], clock_ratio_select,
			module_halt_ctrl_a, module_halt_ctrl_b,
			{13'h0000, all_halted, power_state});
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			hrdata_out <= 32'h0000_0000;
		end else if (addr_phase & ~hwrite_in) begin
			hrdata_out <= next_rdata;
		end
	end

	// Never waits, never errors
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end else begin
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			clock_ratio_select <= clk_ctrl_pkg::CLOCK_RATIO_SELECT_RESET;
		end else if (wr_pending && wr_addr == clk_ctrl_pkg::CLOCK_RATIO_SELECT_ADDR) begin
			clock_ratio_select <= masked_write(clock_ratio_select, hwdata_in[15:0],
				clk_ctrl_pkg::CLOCK_RATIO_SELECT_MASK);
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			module_halt_ctrl_a <= clk_ctrl_pkg::MODULE_HALT_CTRL_A_RESET;
		end else if (wr_pending && wr_addr == clk_ctrl_pkg::MODULE_HALT_CTRL_A_ADDR) begin
			module_halt_ctrl_a <= masked_write(module_halt_ctrl_a, hwdata_in[15:0],
				clk_ctrl_pkg::MODULE_HALT_CTRL_A_MASK);
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			module_halt_ctrl_b <= clk_ctrl_pkg::MODULE_HALT_CTRL_B_RESET;
		end else if (wr_pending && wr_addr == clk_ctrl_pkg::MODULE_HALT_CTRL_B_ADDR) begin
			module_halt_ctrl_b <= masked_write(module_halt_ctrl_b, hwdata_in[15:0],
				clk_ctrl_pkg::MODULE_HALT_CTRL_B_MASK);
		end
	end

	// ------------------------------------------------------------
	// Derived clocks
	// ------------------------------------------------------------
	assign sys_sel = clock_ratio_select[clk_ctrl_pkg::SYS_SEL_LSB +: 3];
	assign periph_sel = clock_ratio_select[clk_ctrl_pkg::PERIPH_SEL_LSB +: 3];
	assign extbus_sel = clock_ratio_select[clk_ctrl_pkg::EXTBUS_SEL_LSB +: 3];

	// Each divider reloads only at its period end, so no short tick appears
	clk_ratio_div #(
		.SEL_W(3)
	) sys_div (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.sel_in(sys_sel),
		.tick_out(sys_tick)
	);

	clk_ratio_div #(
		.SEL_W(3)
	) periph_div (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.sel_in(periph_sel),
		.tick_out(periph_tick)
	);

	clk_ratio_div #(
		.SEL_W(3)
	) extbus_div (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.sel_in(extbus_sel),
		.tick_out(extbus_tick)
	);

	// ------------------------------------------------------------
	// Wake input synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			wake_meta <= 1'b0;
			wake_s2 <= 1'b0;
			wake_s3 <= 1'b0;
		end else begin
			wake_meta <= wake_in;
			wake_s2 <= wake_meta;
			wake_s3 <= wake_s2;
		end
	end

	// Level moves only when the two later stages agree
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			wake_level <= 1'b0;
		end else if (wake_s2 == wake_s3) begin
			wake_level <= wake_s3;
		end
	end

	// ------------------------------------------------------------
	// Power state
	// ------------------------------------------------------------
	assign all_halted =
		((module_halt_ctrl_a & clk_ctrl_pkg::HALT_A_MODULE_MASK)
			== clk_ctrl_pkg::HALT_A_MODULE_MASK) &&
		((module_halt_ctrl_b & clk_ctrl_pkg::MODULE_HALT_CTRL_B_MASK)
			== clk_ctrl_pkg::MODULE_HALT_CTRL_B_MASK);

	always_comb begin
		next_power_state = power_state;
		case (power_state)
			clk_ctrl_pkg::POWER_RUN: begin
				if (sleep_req_in) begin
					// Enable bit off keeps a plain sleep
					if (module_halt_ctrl_a[clk_ctrl_pkg::ALL_CLOCK_STOP_ENABLE_BIT]
						&& all_halted) begin
						next_power_state = clk_ctrl_pkg::POWER_ALL_STOP;
					end else begin
						next_power_state = clk_ctrl_pkg::POWER_SLEEP;
					end
				end
			end
			clk_ctrl_pkg::POWER_SLEEP: begin
				if (wake_level) begin
					next_power_state = clk_ctrl_pkg::POWER_RUN;
				end
			end
			clk_ctrl_pkg::POWER_ALL_STOP: begin
				if (wake_level) begin
					next_power_state = clk_ctrl_pkg::POWER_RUN;
				end
			end
			default: begin
				next_power_state = clk_ctrl_pkg::POWER_RUN;
			end
		endcase
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			power_state <= clk_ctrl_pkg::POWER_RUN;
		end else begin
			power_state <= next_power_state;
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			all_stop_out <= 1'b0;
		end else begin
			all_stop_out <= (next_power_state == clk_ctrl_pkg::POWER_ALL_STOP);
		end
	end

	// ------------------------------------------------------------
	// Derived clock ticks
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			sys_tick_out <= 1'b0;
			periph_tick_out <= 1'b0;
			extbus_tick_out <= 1'b0;
		end else begin
			sys_tick_out <= sys_tick;
			periph_tick_out <= periph_tick;
			extbus_tick_out <= extbus_tick;
		end
	end

	// ------------------------------------------------------------
	// Module clock gates
	// ------------------------------------------------------------
	// Gate is a tick mask, so a halt cuts only whole periods
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			clk_en_out <= '0;
		end else begin
			// Core stops in any sleep, the rest keep their tick in plain sleep
			clk_en_out.cpu <= sys_tick &&
				power_state == clk_ctrl_pkg::POWER_RUN;
			clk_en_out.dma_ctrl <= sys_tick &&
				!module_halt_ctrl_a[clk_ctrl_pkg::HALT_DMA_CTRL_BIT];
			clk_en_out.data_transfer_ctrl <= sys_tick &&
				!module_halt_ctrl_a[clk_ctrl_pkg::HALT_TRANSFER_CTRL_BIT];
			clk_en_out.adc_unit1 <= periph_tick &&
				!module_halt_ctrl_a[clk_ctrl_pkg::HALT_ADC_UNIT1_BIT];
			clk_en_out.adc_unit0 <= periph_tick &&
				!module_halt_ctrl_a[clk_ctrl_pkg::HALT_ADC_UNIT0_BIT];
			clk_en_out.timer_upper <= periph_tick &&
				!module_halt_ctrl_a[clk_ctrl_pkg::HALT_TIMER_UPPER_BIT];
			clk_en_out.timer_lower <= periph_tick &&
				!module_halt_ctrl_a[clk_ctrl_pkg::HALT_TIMER_LOWER_BIT];
			clk_en_out.pulse_pattern_gen <= periph_tick &&
				!module_halt_ctrl_b[clk_ctrl_pkg::HALT_PULSE_PATTERN_BIT];
			clk_en_out.serial_ch4 <= periph_tick &&
				!module_halt_ctrl_b[clk_ctrl_pkg::HALT_SERIAL_CH4_BIT];
			clk_en_out.serial_ch3 <= periph_tick &&
				!module_halt_ctrl_b[clk_ctrl_pkg::HALT_SERIAL_CH3_BIT];
			// Bus and ports only fall silent in all-stop mode
			clk_en_out.bus_ctrl <= extbus_tick &&
				power_state != clk_ctrl_pkg::POWER_ALL_STOP;
			clk_en_out.io_ports <= periph_tick &&
				power_state != clk_ctrl_pkg::POWER_ALL_STOP;
		end
	end

	// Bus slave runs on the ungated core clock only as a modelling limitation:
	// registers stay reachable in all-stop mode so software can recover.

endmodule : clock_select_module_stop

// File: clock_select_module_stop_props.sv
// Purpose: Port checker for the clock ratio and module halt block
// Assumes: Zero-wait bus, one clock domain
// Notes: Registers are mirrored from observed bus writes
`timescale 1ns/1ps
module clock_select_module_stop_props (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	input wire logic [31:0] hrdata_out,
	input wire logic hreadyout_out,
	input wire logic hresp_out,
	input wire logic sleep_req_in,
	input wire clk_ctrl_pkg::module_clk_en_t clk_en_out,
	input wire logic sys_tick_out,
	input wire logic periph_tick_out,
	input wire logic extbus_tick_out,
	input wire logic all_stop_out
);
	// ------------------------------------------------------------
	// Register mirror
	// ------------------------------------------------------------
	logic wr_q;
	logic [23:0] wa_q;
	logic [15:0] m_r, m_a, m_b;
	logic [4:0] age;
	logic [3:0] gap;
	logic seen;
	logic [11:0] hm;
	assign hm = {1'b0, m_a[13], m_a[12], m_a[4], m_a[3], m_a[1], m_a[0], m_b[15], m_b[12],
		m_b[11], 2'b00};
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			wr_q <= 1'b0;
			wa_q <= 24'h0;
			m_r <= 16'h0;
			m_a <= 16'h0;
			m_b <= 16'h0;
			age <= 5'h0;
		end else begin
			wr_q <= hsel_in && hready_in && htrans_in[1] && hwrite_in;
			wa_q <= haddr_in[23:0];
			if (wr_q && wa_q == clk_ctrl_pkg::CLOCK_RATIO_SELECT_ADDR)
				m_r <= hwdata_in[15:0] & clk_ctrl_pkg::CLOCK_RATIO_SELECT_MASK;
			if (wr_q && wa_q == clk_ctrl_pkg::MODULE_HALT_CTRL_A_ADDR)
				m_a <= hwdata_in[15:0] & clk_ctrl_pkg::MODULE_HALT_CTRL_A_MASK;
			if (wr_q && wa_q == clk_ctrl_pkg::MODULE_HALT_CTRL_B_ADDR)
				m_b <= hwdata_in[15:0] & clk_ctrl_pkg::MODULE_HALT_CTRL_B_MASK;
			// Settle time covers the slowest period plus latency
			age <= wr_q ? 5'h0 : (age == 5'h1f ? age : age + 5'h1);
		end
	end
	// Gap since the last peripheral tick; forgotten across all-stop
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			gap <= 4'h0;
			seen <= 1'b0;
		end else begin
			gap <= periph_tick_out ? 4'h0 : (gap == 4'hf ? gap : gap + 4'h1);
			seen <= !all_stop_out && (seen || periph_tick_out);
		end
	end
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	a_bus_okay: assert property (hreadyout_out && !hresp_out)
		else $error("bus not ready or error response");
	a_upper_zero: assert property (hrdata_out[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	a_sys_x8: assert property ((age > 5'd11 && m_r[10:8] == 3'h0 && !all_stop_out) |-> sys_tick_out)
		else $error("system tick missing at code zero");
	a_periph_x4: assert property ((age > 5'd11 && m_r[6:4] == 3'h1 && periph_tick_out)
		|=> !periph_tick_out ##1 periph_tick_out)
		else $error("peripheral tick not every second cycle");
	a_extbus_x4: assert property ((age > 5'd11 && m_r[2:0] == 3'h1 && extbus_tick_out)
		|=> !extbus_tick_out ##1 extbus_tick_out)
		else $error("bus tick not every second cycle");
	a_halt_gates: assert property (age > 5'd11 |-> (clk_en_out & hm) == 12'h000)
		else $error("halted module still enabled");
	a_stop_entry: assert property ($rose(all_stop_out) |-> $past(sleep_req_in) && m_a[15]
		&& (m_a & 16'h301b) == 16'h301b && m_b == 16'h9800)
		else $error("all-stop entered without its conditions");
	a_stop_gates: assert property ((all_stop_out && $past(all_stop_out))
		|-> !clk_en_out.cpu && !clk_en_out.bus_ctrl && !clk_en_out.io_ports)
		else $error("clock running in all-stop");
	a_tick_spacing: assert property ((periph_tick_out && seen) |-> gap inside {0, 1, 3, 7})
		else $error("runt peripheral period");
	c_all_stop: cover property ($rose(all_stop_out));
	c_plain_sleep: cover property (sleep_req_in && !m_a[15]);
	c_periph_x4: cover property (m_r[6:4] == 3'h1 && periph_tick_out);
endmodule : clock_select_module_stop_props

bind clock_select_module_stop clock_select_module_stop_props u_props (
	.core_clk_in(core_clk_in), .reset_in(reset_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
	.htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
	.hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
	.sleep_req_in(sleep_req_in), .clk_en_out(clk_en_out), .sys_tick_out(sys_tick_out),
	.periph_tick_out(periph_tick_out), .extbus_tick_out(extbus_tick_out),
	.all_stop_out(all_stop_out));

// File: clock_select_module_stop_tb.sv
// Purpose: Self-checking bench for the clock ratio and module halt block
// Assumes: Zero-wait slave, but every wait is bounded
// Notes: Tick and enable pulses are counted over fixed windows
`timescale 1ns/1ps
module clock_select_module_stop_tb;
	localparam logic [23:0] RA = clk_ctrl_pkg::CLOCK_RATIO_SELECT_ADDR;
	localparam logic [23:0] AA = clk_ctrl_pkg::MODULE_HALT_CTRL_A_ADDR;
	localparam logic [23:0] BA = clk_ctrl_pkg::MODULE_HALT_CTRL_B_ADDR;
	localparam logic [23:0] SA = clk_ctrl_pkg::CLOCK_STATUS_ADDR;
	logic core_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic hsel_in = 1'b0;
	logic [31:0] haddr_in = 32'h0;
	logic [1:0] htrans_in = 2'h0;
	logic hwrite_in = 1'b0;
	logic [2:0] hsize_in = 3'h2;
	logic [31:0] hwdata_in = 32'h0;
	logic sleep_req_in = 1'b0;
	logic wake_in = 1'b0;
	logic [31:0] hrdata_out;
	logic hreadyout_out, hresp_out, sys_tick_out, periph_tick_out, extbus_tick_out, all_stop_out;
	clk_ctrl_pkg::module_clk_en_t clk_en_out;
	int err_total = 0;
	int n_checks = 0;
	integer seed = 32'hc247;
	int cnt[12];
	int ts, tp, te, n;
	logic [31:0] rd, wd, mk;
	logic [23:0] ad;
	logic [15:0] va, vb;
	logic [11:0] hm;

	always #2.5 core_clk_in = ~core_clk_in;

	clock_select_module_stop u_clock_select_module_stop (
		.core_clk_in(core_clk_in), .reset_in(reset_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
		.htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
		.hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
		.hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .sleep_req_in(sleep_req_in),
		.wake_in(wake_in), .clk_en_out(clk_en_out), .sys_tick_out(sys_tick_out),
		.periph_tick_out(periph_tick_out), .extbus_tick_out(extbus_tick_out),
		.all_stop_out(all_stop_out));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic int per(input logic [2:0] c);
		return (c == 3'h0) ? 1 : (c == 3'h1) ? 2 : (c == 3'h2) ? 4 : 8;
	endfunction : per
	function automatic logic [11:0] hmask(input logic [15:0] a, input logic [15:0] b);
		return {1'b0, a[13], a[12], a[4], a[3], a[1], a[0], b[15], b[12], b[11], 2'b00};
	endfunction : hmask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wait_ready;
		int k;
		k = 0;
		do begin
			@(posedge core_clk_in);
			k++;
			if (k > 50) begin
				err_total++;
				conclude();
			end
		end while (hreadyout_out !== 1'b1);
	endtask : wait_ready
	// Address phase held until hready, then data phase
	task automatic bus(input logic w, input logic [23:0] a, input logic [31:0] d);
		hsel_in <= 1'b1;
		haddr_in <= {8'h00, a};
		htrans_in <= 2'h2;
		hwrite_in <= w;
		wait_ready();
		hsel_in <= 1'b0;
		htrans_in <= 2'h0;
		hwdata_in <= d;
		wait_ready();
		rd = hrdata_out;
	endtask : bus
	task automatic rchk(input logic [23:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(rd, e);
	endtask : rchk
	task automatic count(input int len);
		for (int i = 0; i < 12; i++)
			cnt[i] = 0;
		ts = 0;
		tp = 0;
		te = 0;
		repeat (len) begin
			@(posedge core_clk_in);
			for (int i = 0; i < 12; i++)
				cnt[i] += (clk_en_out[i] === 1'b1);
			ts += (sys_tick_out === 1'b1);
			tp += (periph_tick_out === 1'b1);
			te += (extbus_tick_out === 1'b1);
		end
	endtask : count

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge core_clk_in);
		reset_in <= 1'b0;
		@(posedge core_clk_in);
		rchk(RA, 32'h0);
		rchk(AA, 32'h0);
		rchk(BA, 32'h0);
		rchk(SA, 32'h0);
		rchk(24'hfffe00, 32'h0);
		for (int j = 0; j < 12; j++) begin
			wd = $random(seed);
			ad = (j % 3 == 0) ? RA : (j % 3 == 1) ? AA : BA;
			mk = (j % 3 == 0) ? 32'h0777 : (j % 3 == 1) ? 32'hb01b : 32'h9800;
			bus(1'b1, ad, wd);
			rchk(ad, wd & mk);
		end
		// Same code in all three fields; code 4 shows the clamp
		for (int c = 0; c < 5; c++) begin
			va = {5'h0, 3'(c), 1'b0, 3'(c), 1'b0, 3'(c)};
			bus(1'b1, RA, {16'h0, va});
			repeat (20) @(posedge core_clk_in);
			count(64);
			check(ts, 64 / per(3'(c)));
			check(tp, 64 / per(3'(c)));
			check(te, 64 / per(3'(c)));
		end
		bus(1'b1, AA, 32'h0);
		bus(1'b1, BA, 32'h0);
		bus(1'b1, RA, 32'h0300);
		repeat (20) @(posedge core_clk_in);
		count(64);
		check(cnt[11], 8);
		check(cnt[10], 8);
		check(cnt[9], 8);
		check(cnt[7], 64);
		bus(1'b1, RA, 32'h0);
		for (int k = 0; k < 6; k++) begin
			va = (k == 0) ? 16'h301b : 16'($random(seed)) & 16'h301b;
			vb = (k == 0) ? 16'h9800 : 16'($random(seed)) & 16'h9800;
			bus(1'b1, AA, {16'h0, va});
			bus(1'b1, BA, {16'h0, vb});
			repeat (20) @(posedge core_clk_in);
			count(16);
			hm = hmask(va, vb);
			for (int i = 0; i < 12; i++)
				check(cnt[i], hm[i] ? 0 : 16);
		end
		// Plain sleep, all-stop, and enable set with one module left running
		for (int s = 0; s < 3; s++) begin
			bus(1'b1, AA, (s == 0) ? 32'h301b : 32'hb01b);
			bus(1'b1, BA, (s == 2) ? 32'h1800 : 32'h9800);
			sleep_req_in <= 1'b1;
			@(posedge core_clk_in);
			sleep_req_in <= 1'b0;
			@(posedge core_clk_in);
			check(all_stop_out, s == 1);
			count(16);
			check(cnt[11], 0);
			check(cnt[1], (s == 1) ? 0 : 16);
			check(cnt[0], (s == 1) ? 0 : 16);
			rchk(SA, (s == 0) ? 5 : (s == 1) ? 6 : 1);
			wake_in <= 1'b1;
			n = 0;
			do begin
				@(posedge core_clk_in);
				n++;
				if (n > 40) begin
					err_total++;
					conclude();
				end
			end while (clk_en_out.cpu !== 1'b1);
			wake_in <= 1'b0;
			check(all_stop_out, 0);
		end
		reset_in <= 1'b1;
		repeat (4) @(posedge core_clk_in);
		reset_in <= 1'b0;
		@(posedge core_clk_in);
		rchk(AA, 32'h0);
		rchk(RA, 32'h0);
		conclude();
	end
endmodule : clock_select_module_stop_tb
